/* File: rtl/usb_reset_pkg.sv */
package usb_reset_pkg;
  // ahb register byte offsets
  localparam logic [7:0] addr_bulk_in_cs      = 8'h00;
  localparam logic [7:0] addr_bulk_out_cs     = 8'h04;
  localparam logic [7:0] addr_stall           = 8'h08;
  localparam logic [7:0] addr_toggle          = 8'h0c;
  localparam logic [7:0] addr_function_addr   = 8'h10;
  localparam logic [7:0] addr_config          = 8'h14;
  localparam logic [7:0] addr_cpu_cs          = 8'h18;
  localparam logic [7:0] addr_usb_cs          = 8'h1c;
  localparam logic [7:0] addr_irq_enable      = 8'h20;
  localparam logic [7:0] addr_irq_request     = 8'h24;
  localparam logic [7:0] addr_in_bc_base      = 8'h40;
  localparam logic [7:0] addr_out_bc_base     = 8'h60;
  localparam logic [7:0] addr_event           = 8'h28;
  localparam logic [7:0] addr_status          = 8'h2c;
  localparam logic [7:0] addr_serial_ctrl     = 8'h30;

  // field positions
  localparam int cpu_cs_reset_bit   = 0;
  localparam int cpu_cs_clkoe_bit   = 1;
  localparam int usb_cs_reenumeration_flag_bit   = 1;
  localparam int usb_cs_wakesrc_bit = 7;
  localparam int event_disconnect_bit = 0;
  localparam int event_suspend_ok_bit = 1;
  localparam int in_armed_bit       = 1;
  localparam int out_armed_bit      = 1;
  localparam int irq_break_bit      = 3;

  // reset values
  localparam logic [7:0] cpu_cs_reset_value = 8'h03;
  localparam logic [7:0] usb_cs_reset_value = 8'h04;
  localparam logic [7:0] out_cs_armed_value = 8'h02;

  // usb interrupt vectors
  localparam logic [3:0] vector_none    = 4'h0;
  localparam logic [3:0] vector_reset   = 4'h4;
  localparam logic [3:0] vector_suspend = 4'h3;

  // timing
  localparam int clock_mhz          = 200;
  localparam int bus_reset_time_us  = 10000;
  localparam int suspend_time_us    = 3000;
  localparam int bus_reset_cycles   = bus_reset_time_us * clock_mhz;
  localparam int suspend_cycles     = suspend_time_us * clock_mhz;

  typedef enum logic [1:0]
  {
    st_active    = 2'b00,
    st_suspended = 2'b01,
    st_sleep     = 2'b10
  } power_state_t;
endpackage

/* File: rtl/line_timer.sv */
`timescale 1ns/1ps
// counts consecutive cycles of a line condition, pulses once on reaching the limit
module line_timer #(
  parameter int limit = 2000000
) (
  input  wire logic i_clock,     // core clock
  input  wire logic i_rst_n,     // async reset, active low
  input  wire logic i_condition, // line condition present this cycle
  output logic      o_hit        // one-cycle pulse at limit
);
  localparam int cw = $clog2(limit + 1);
  logic [cw-1:0] count_reg;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      count_reg <= '0;
    else if (!i_condition)
      count_reg <= '0;
    else if (count_reg != cw'(limit))
      count_reg <= count_reg + cw'(1);
  end

  assign o_hit = i_condition && (count_reg == cw'(limit - 1));
endmodule

/* File: rtl/ahb_reg_port.sv */
`timescale 1ns/1ps
// ahb-lite slave front end: latches address phase, zero wait state, always okay
module ahb_reg_port (
  input  wire logic        i_clock,     // core clock
  input  wire logic        i_rst_n,     // async reset, active low
  input  wire logic        i_hsel,      // slave select
  input  wire logic [31:0] i_haddr,     // address
  input  wire logic [1:0]  i_htrans,    // transfer type
  input  wire logic        i_hwrite,    // write
  input  wire logic        i_hready,    // bus ready
  output logic             o_wr_en,     // write strobe in data phase
  output logic             o_rd_en,     // read address phase accepted
  output logic [7:0]       o_wr_addr,   // latched write offset
  output logic             o_hreadyout, // slave ready
  output logic [1:0]       o_hresp      // response
);
  logic       wr_pend_reg;
  logic [7:0] addr_reg;
  logic       take;

  assign take = i_hsel && i_hready && i_htrans[1];

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end
    else if (i_hready)
    begin
      wr_pend_reg <= take && i_hwrite;
      addr_reg    <= i_haddr[7:0];
    end
  end

  assign o_wr_en     = wr_pend_reg;
  assign o_rd_en     = take && !i_hwrite;
  assign o_wr_addr   = addr_reg;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 2'b00;
endmodule

/* File: rtl/usb_device_reset_effects.sv */
`timescale 1ns/1ps
module usb_device_reset_effects #(
  parameter int num_ep           = 8,
  parameter int bus_reset_cycles = usb_reset_pkg::bus_reset_cycles,
  parameter int suspend_cycles   = usb_reset_pkg::suspend_cycles
) (
  input  wire logic        i_clock,         // core clock, 200 mhz
  input  wire logic        i_rst_n,         // reset pin, async, active low
  input  wire logic        i_hsel,          // ahb select
  input  wire logic [31:0] i_haddr,         // ahb address
  input  wire logic [1:0]  i_htrans,        // ahb transfer type
  input  wire logic        i_hwrite,        // ahb write
  input  wire logic [2:0]  i_hsize,         // ahb size, word only
  input  wire logic [31:0] i_hwdata,        // ahb write data
  input  wire logic        i_hready,        // ahb ready
  output logic [31:0]      o_hrdata,        // ahb read data
  output logic             o_hreadyout,     // ahb slave ready
  output logic [1:0]       o_hresp,         // ahb response
  input  wire logic        i_line_se0,      // link shows se0
  input  wire logic        i_line_idle_j,   // link shows idle j
  input  wire logic        i_wake_n,        // wake pin, active low
  input  wire logic        i_cpu_idle,      // firmware entered idle
  output logic             o_usb_irq_line,  // usb interrupt request
  output logic [3:0]       o_usb_vector,    // usb interrupt vector
  output logic             o_cpu_reset,     // processor held in reset
  output logic             o_osc_enable,    // oscillator run enable
  output logic             o_clock_output_en, // clock output enable
  output logic             o_serial_reset   // two-wire serial controller reset
);
  localparam int aw = 8;

  logic [num_ep-1:0] in_armed_reg;
  logic [num_ep-1:0] out_armed_reg;
  logic [num_ep-1:0] in_stall_reg;
  logic [num_ep-1:0] out_stall_reg;
  logic [2*num_ep-1:0] toggle_reg;
  logic [6:0]        function_address_reg;
  logic [7:0]        config_reg;
  logic [7:0]        alt_setting_reg;
  logic [7:0]        cpu_control_status;
  logic [7:0]        usb_control_status_reg;
  logic [7:0]        irq_enable_reg;
  logic [7:0]        irq_request_reg;
  logic              vector_pending_reg;
  logic [3:0]        vector_reg;
  logic [7:0]        serial_ctrl_reg;
  logic [31:0]       hrdata_reg;
  usb_reset_pkg::power_state_t power_reg;

  logic       wr_en;
  logic       rd_en;
  logic [aw-1:0] wr_addr;
  logic       bus_reset;
  logic       suspend_hit;
  logic       disconnect;
  logic       cpu_reset;
  logic       cpu_reset_d_reg;
  logic       cpu_release;
  logic       in_bc_write;
  logic       out_bc_write;
  logic [2:0] bc_ep;

  ahb_reg_port u_port (
    .i_clock     (i_clock),
    .i_rst_n     (i_rst_n),
    .i_hsel      (i_hsel),
    .i_haddr     (i_haddr),
    .i_htrans    (i_htrans),
    .i_hwrite    (i_hwrite),
    .i_hready    (i_hready),
    .o_wr_en     (wr_en),
    .o_rd_en     (rd_en),
    .o_wr_addr   (wr_addr),
    .o_hreadyout (o_hreadyout),
    .o_hresp     (o_hresp)
  );

  // the host keeps se0 for the full time; shorter glitches are ignored
  line_timer #(.limit(bus_reset_cycles)) u_reset_timer (
    .i_clock     (i_clock),
    .i_rst_n     (i_rst_n),
    .i_condition (i_line_se0),
    .o_hit       (bus_reset)
  );

  // a low wake pin holds off suspend, so the idle count restarts while it is low
  line_timer #(.limit(suspend_cycles)) u_suspend_timer (
    .i_clock     (i_clock),
    .i_rst_n     (i_rst_n),
    .i_condition (i_line_idle_j && i_wake_n && power_reg == usb_reset_pkg::st_active),
    .o_hit       (suspend_hit)
  );

  assign disconnect   = wr_en && wr_addr == usb_reset_pkg::addr_event
                        && i_hwdata[usb_reset_pkg::event_disconnect_bit];
  assign cpu_reset    = cpu_control_status[usb_reset_pkg::cpu_cs_reset_bit];
  assign cpu_release  = cpu_reset_d_reg && !cpu_reset;
  assign in_bc_write  = wr_en && wr_addr[7:5] == usb_reset_pkg::addr_in_bc_base[7:5];
  assign out_bc_write = wr_en && wr_addr[7:5] == usb_reset_pkg::addr_out_bc_base[7:5];
  assign bc_ep        = wr_addr[4:2];

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cpu_reset_d_reg <= 1'b1;
    else
      cpu_reset_d_reg <= cpu_reset;
  end

  // endpoint arming: every reset source resolved in one edge, highest first
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      in_armed_reg  <= '0;
      out_armed_reg <= '0;
    end
    else if (cpu_reset)
    begin
      in_armed_reg  <= '0;
      out_armed_reg <= '0;
    end
    else if (disconnect)
    begin
      in_armed_reg  <= '0;
      out_armed_reg <= '1;
    end
    else if (bus_reset)
    begin
      in_armed_reg  <= '0;
    end
    else if (cpu_release)
      out_armed_reg <= '1;
    else if (in_bc_write)
      in_armed_reg[bc_ep] <= 1'b1;
    else if (out_bc_write)
      out_armed_reg[bc_ep] <= 1'b1;
    else if (wr_en && wr_addr == usb_reset_pkg::addr_bulk_in_cs)
      in_armed_reg  <= i_hwdata[num_ep-1:0];
    else if (wr_en && wr_addr == usb_reset_pkg::addr_bulk_out_cs)
      out_armed_reg <= i_hwdata[num_ep-1:0];
  end

  // stall bits: processor reset and bus reset leave them alone
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      in_stall_reg  <= '0;
      out_stall_reg <= '0;
    end
    else if (disconnect)
    begin
      in_stall_reg  <= '0;
      out_stall_reg <= '0;
    end
    else if (wr_en && wr_addr == usb_reset_pkg::addr_stall)
    begin
      in_stall_reg  <= i_hwdata[num_ep-1:0];
      out_stall_reg <= i_hwdata[num_ep+15:16];
    end
  end

  // device identity state: toggles, address, configuration
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      toggle_reg           <= '0;
      function_address_reg <= 7'h00;
      config_reg           <= 8'h00;
      alt_setting_reg      <= 8'h00;
    end
    else if (bus_reset || disconnect)
    begin
      toggle_reg           <= '0;
      function_address_reg <= 7'h00;
      config_reg           <= 8'h00;
      alt_setting_reg      <= 8'h00;
    end
    else if (wr_en && wr_addr == usb_reset_pkg::addr_toggle)
      toggle_reg <= i_hwdata[2*num_ep-1:0];
    else if (wr_en && wr_addr == usb_reset_pkg::addr_function_addr)
      function_address_reg <= i_hwdata[6:0];
    else if (wr_en && wr_addr == usb_reset_pkg::addr_config)
    begin
      config_reg      <= i_hwdata[7:0];
      alt_setting_reg <= i_hwdata[15:8];
    end
  end

  // cpu control: only the pin resets it; other resets are unaffected
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cpu_control_status <= usb_reset_pkg::cpu_cs_reset_value;
    else if (wr_en && wr_addr == usb_reset_pkg::addr_cpu_cs)
      cpu_control_status <= i_hwdata[7:0];
  end

  // reenumeration flag kept through bus reset and disconnect
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      usb_control_status_reg <= usb_reset_pkg::usb_cs_reset_value;
    else if (power_reg != usb_reset_pkg::st_active && !i_wake_n)
      usb_control_status_reg[usb_reset_pkg::usb_cs_wakesrc_bit] <= 1'b1;
    else if (wr_en && wr_addr == usb_reset_pkg::addr_usb_cs)
    begin
      usb_control_status_reg[6:0] <= i_hwdata[6:0];
      if (i_hwdata[usb_reset_pkg::usb_cs_wakesrc_bit])
        usb_control_status_reg[usb_reset_pkg::usb_cs_wakesrc_bit] <= 1'b0;
    end
  end

  // enables cleared by processor reset; requests other than the break bit survive it
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      irq_enable_reg <= 8'h00;
    else if (cpu_reset)
      irq_enable_reg <= 8'h00;
    else if (wr_en && wr_addr == usb_reset_pkg::addr_irq_enable)
      irq_enable_reg <= i_hwdata[7:0];
  end

  // break bit lives in the request register; cleared by processor reset
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      irq_request_reg <= 8'h00;
    else if (cpu_reset)
      irq_request_reg[usb_reset_pkg::irq_break_bit] <= 1'b0;
    else if (wr_en && wr_addr == usb_reset_pkg::addr_irq_request)
      irq_request_reg <= irq_request_reg & ~i_hwdata[7:0];
  end

  // usb interrupt: event sets beat a firmware acknowledge in the same cycle
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      vector_pending_reg <= 1'b0;
      vector_reg         <= usb_reset_pkg::vector_none;
    end
    else if (bus_reset)
    begin
      vector_pending_reg <= 1'b1;
      vector_reg         <= usb_reset_pkg::vector_reset;
    end
    else if (suspend_hit)
    begin
      vector_pending_reg <= 1'b1;
      vector_reg         <= usb_reset_pkg::vector_suspend;
    end
    else if (wr_en && wr_addr == usb_reset_pkg::addr_status && i_hwdata[0])
      vector_pending_reg <= 1'b0;
  end

  // suspend sequence; the core clock stops in sleep, wake restarts it
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      power_reg <= usb_reset_pkg::st_active;
    else
    begin
      unique case (power_reg)
        usb_reset_pkg::st_active:
          if (suspend_hit && i_wake_n)
            power_reg <= usb_reset_pkg::st_suspended;
        usb_reset_pkg::st_suspended:
          if (!i_line_idle_j || !i_wake_n)
            power_reg <= usb_reset_pkg::st_active;
          else if (i_cpu_idle)
            power_reg <= usb_reset_pkg::st_sleep;
        usb_reset_pkg::st_sleep:
          if (!i_line_idle_j || !i_wake_n)
            power_reg <= usb_reset_pkg::st_active;
        default:
          power_reg <= usb_reset_pkg::st_active;
      endcase
    end
  end

  // serial controller control only sees the pin reset
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      serial_ctrl_reg <= 8'h00;
    else if (wr_en && wr_addr == usb_reset_pkg::addr_serial_ctrl)
      serial_ctrl_reg <= i_hwdata[7:0];
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      hrdata_reg <= 32'h00000000;
    else if (rd_en)
    begin
      unique case (i_haddr[7:0])
        usb_reset_pkg::addr_bulk_in_cs:    hrdata_reg <= 32'(in_armed_reg);
        usb_reset_pkg::addr_bulk_out_cs:   hrdata_reg <= 32'(out_armed_reg);
        usb_reset_pkg::addr_stall:
          hrdata_reg <= {8'h00, 8'(out_stall_reg), 8'h00, 8'(in_stall_reg)};
        usb_reset_pkg::addr_toggle:        hrdata_reg <= 32'(toggle_reg);
        usb_reset_pkg::addr_function_addr: hrdata_reg <= 32'(function_address_reg);
        usb_reset_pkg::addr_config:
          hrdata_reg <= {16'h0000, alt_setting_reg, config_reg};
        usb_reset_pkg::addr_cpu_cs:        hrdata_reg <= 32'(cpu_control_status);
        usb_reset_pkg::addr_usb_cs:        hrdata_reg <= 32'(usb_control_status_reg);
        usb_reset_pkg::addr_irq_enable:    hrdata_reg <= 32'(irq_enable_reg);
        usb_reset_pkg::addr_irq_request:   hrdata_reg <= 32'(irq_request_reg);
        usb_reset_pkg::addr_status:
          hrdata_reg <= {24'h000000, 2'(power_reg), vector_reg, 1'b0, vector_pending_reg};
        usb_reset_pkg::addr_serial_ctrl:   hrdata_reg <= 32'(serial_ctrl_reg);
        default:                           hrdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign o_hrdata          = hrdata_reg;
  assign o_usb_irq_line    = vector_pending_reg;
  assign o_usb_vector      = vector_reg;
  assign o_cpu_reset       = cpu_reset;
  assign o_osc_enable      = power_reg != usb_reset_pkg::st_sleep;
  // clock output keeps running under the pin reset since its enable resets high
  assign o_clock_output_en = cpu_control_status[usb_reset_pkg::cpu_cs_clkoe_bit];
  assign o_serial_reset    = !i_rst_n;
endmodule

/* File: verif/usb_host_model.sv */
`timescale 1ns/1ps
// upstream port: j/k traffic, a bus reset, or a quiet idle j line
module usb_host_model #(
  parameter int reset_len = 20
) (
  input  wire logic       i_clock,      // core clock
  input  wire logic [1:0] i_mode,       // 0 traffic, 1 bus reset, 2 idle j
  output logic            o_line_se0,   // link in se0
  output logic            o_line_idle_j // link in idle j
);
  int   hold  = 0;
  logic phase = 1'b0;
  // a started reset is never cut short, even if the bench drops the request early
  always @(posedge i_clock)
  begin
    phase <= !phase;
    if (i_mode == 2'd1 && hold == 0)
      hold <= reset_len;
    else if (hold > 0)
      hold <= hold - 1;
  end
  assign o_line_se0    = (i_mode == 2'd1) || (hold > 0);
  // traffic swaps j and k every cycle so no idle run can build up
  assign o_line_idle_j = !o_line_se0 && (i_mode == 2'd2 || phase);
endmodule

/* File: verif/usb_reset_effects_sva.sv */
`timescale 1ns/1ps
module usb_reset_effects_sva #(
  parameter int bus_reset_cycles = 20,
  parameter int suspend_cycles   = 12
) (
  input wire logic        i_clock,           // core clock
  input wire logic        i_rst_n,           // reset pin
  input wire logic        i_hsel,            // ahb select
  input wire logic [1:0]  i_htrans,          // ahb transfer
  input wire logic        i_hwrite,          // ahb write
  input wire logic        i_hready,          // ahb ready
  input wire logic        i_line_se0,        // link se0
  input wire logic        i_line_idle_j,     // link idle j
  input wire logic        i_wake_n,          // wake pin
  input wire logic        i_cpu_idle,        // firmware idle
  input wire logic [31:0] o_hrdata,          // read data
  input wire logic        o_hreadyout,       // slave ready
  input wire logic [1:0]  o_hresp,           // response
  input wire logic        o_usb_irq_line,    // usb irq
  input wire logic [3:0]  o_usb_vector,      // irq vector
  input wire logic        o_cpu_reset,       // cpu reset
  input wire logic        o_osc_enable,      // oscillator
  input wire logic        o_clock_output_en, // clock output
  input wire logic        o_serial_reset     // serial reset
);
  int se0_cnt;
  int idle_cnt;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  // both counters saturate at the limit so the value one below it is seen once per run
  always_ff @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n) se0_cnt <= 0;
    else if (!i_line_se0) se0_cnt <= 0;
    else if (se0_cnt < bus_reset_cycles) se0_cnt <= se0_cnt + 1;
  always_ff @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n) idle_cnt <= 0;
    else if (!i_line_idle_j || !i_wake_n) idle_cnt <= 0;
    else if (idle_cnt < suspend_cycles) idle_cnt <= idle_cnt + 1;

  a_bus_okay: assert property (o_hreadyout && o_hresp == 2'b00)
    else $error("bus answer not ready and okay");
  a_rdata_holds: assert property (!$past(i_hsel && i_hready && i_htrans[1] && !i_hwrite)
    |-> $stable(o_hrdata)) else $error("read data moved without a read");
  a_reset_vector: assert property (
    i_line_se0 && se0_cnt == bus_reset_cycles - 1
    |-> ##[1:3] o_usb_irq_line && o_usb_vector == usb_reset_pkg::vector_reset)
    else $error("bus reset did not raise reset vector");
  a_no_early_reset: assert property (
    i_line_se0 && se0_cnt >= 3 && se0_cnt < bus_reset_cycles - 2 && !o_usb_irq_line
    |=> !o_usb_irq_line) else $error("irq raised by a short se0");
  a_suspend_vector: assert property (
    i_line_idle_j && idle_cnt == suspend_cycles - 1 && i_wake_n && $past(i_wake_n)
    |-> ##[1:3] o_usb_irq_line && o_usb_vector == usb_reset_pkg::vector_suspend)
    else $error("idle j did not raise suspend vector");
  a_sleep_handshake: assert property ($fell(o_osc_enable) |-> $past(i_cpu_idle))
    else $error("oscillator stopped without firmware idle");
  a_wake_restart: assert property (
    !o_osc_enable && (!i_wake_n || !i_line_idle_j) |=> o_osc_enable)
    else $error("no wake on activity or wake pin");
  a_serial_pin: assert property (disable iff (1'b0) o_serial_reset == !i_rst_n)
    else $error("serial reset not tied to reset pin");
  a_pin_state: assert property (disable iff (1'b0)
    !i_rst_n |-> o_cpu_reset && o_clock_output_en && !o_usb_irq_line && o_usb_vector == 4'h0)
    else $error("reset pin state wrong");
endmodule

bind usb_device_reset_effects usb_reset_effects_sva #(
  .bus_reset_cycles(bus_reset_cycles), .suspend_cycles(suspend_cycles)
) chk_u (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hready(i_hready), .i_line_se0(i_line_se0),
  .i_line_idle_j(i_line_idle_j), .i_wake_n(i_wake_n), .i_cpu_idle(i_cpu_idle),
  .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_usb_irq_line(o_usb_irq_line), .o_usb_vector(o_usb_vector), .o_cpu_reset(o_cpu_reset),
  .o_osc_enable(o_osc_enable), .o_clock_output_en(o_clock_output_en),
  .o_serial_reset(o_serial_reset)
);

/* File: verif/test_usb_device_reset_effects.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %0t mismatch got %0h want %0h", $time, got, exp); end end
module test_usb_device_reset_effects;
  localparam int reset_len = 20;
  localparam int idle_len  = 12;
  typedef struct { logic [7:0] addr; logic [31:0] value; } row_t;
  logic        clock     = 1'b0;
  logic        rst_n     = 1'b1;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'b00;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0;
  logic [1:0]  host_mode = 2'd0;
  logic        wake_n    = 1'b1;
  logic        cpu_idle  = 1'b0;
  logic [31:0] hrdata;
  logic [31:0] rdata;
  logic [1:0]  hresp;
  logic [3:0]  vector;
  logic        hready, se0, idle_j, irq, cpu_reset, osc_en, clk_oe, ser_rst;
  int          failures  = 0;
  int          compares  = 0;
  row_t        rows [12] = '{
    '{usb_reset_pkg::addr_cpu_cs, 32'h3}, '{usb_reset_pkg::addr_usb_cs, 32'h4},
    '{usb_reset_pkg::addr_bulk_in_cs, 32'h0}, '{usb_reset_pkg::addr_bulk_out_cs, 32'h0},
    '{usb_reset_pkg::addr_stall, 32'h0}, '{usb_reset_pkg::addr_toggle, 32'h0},
    '{usb_reset_pkg::addr_function_addr, 32'h0}, '{usb_reset_pkg::addr_config, 32'h0},
    '{usb_reset_pkg::addr_irq_enable, 32'h0}, '{usb_reset_pkg::addr_irq_request, 32'h0},
    '{8'h3c, 32'h0}, '{usb_reset_pkg::addr_serial_ctrl, 32'h0}};

  usb_device_reset_effects #(.bus_reset_cycles(reset_len), .suspend_cycles(idle_len)) dut_u (
    .i_clock(clock), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_line_se0(se0),
    .i_line_idle_j(idle_j), .i_wake_n(wake_n), .i_cpu_idle(cpu_idle), .o_usb_irq_line(irq),
    .o_usb_vector(vector), .o_cpu_reset(cpu_reset), .o_osc_enable(osc_en),
    .o_clock_output_en(clk_oe), .o_serial_reset(ser_rst));
  usb_host_model #(.reset_len(reset_len)) host_u (
    .i_clock(clock), .i_mode(host_mode), .o_line_se0(se0), .o_line_idle_j(idle_j));

  initial
    forever #2.5 clock = !clock;

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // starts one edge late so a strobe is never driven twice in one time step
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    for (n = 0; n == 0 || (n < 20 && hready !== 1'b1); n++) @(posedge clock);
    if (n == 20)
    begin
      failures++;
      wrap_up();
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    for (n = 0; n == 0 || (n < 20 && hready !== 1'b1); n++) @(posedge clock);
    rdata = hrdata;
    if (n == 20)
    begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    `CHK(rdata, exp)
  endtask

  task automatic wait_irq(input logic [3:0] vec);
    int n;
    for (n = 0; n < 40 && irq !== 1'b1; n++) @(posedge clock);
    if (n == 40)
    begin
      failures++;
      wrap_up();
    end
    `CHK(vector, vec)
  endtask

  task automatic check_table(input string name);
    for (int i = 0; i < 12; i++) rd_chk(rows[i].addr, rows[i].value);
    $display("test %s done", name);
  endtask

  task automatic set_state();
    wr(usb_reset_pkg::addr_stall, 32'h00030005);
    wr(usb_reset_pkg::addr_toggle, 32'h0000abcd);
    wr(usb_reset_pkg::addr_function_addr, 32'h5);
    wr(usb_reset_pkg::addr_config, 32'h0201);
    wr(usb_reset_pkg::addr_irq_enable, 32'hf);
    wr(usb_reset_pkg::addr_usb_cs, 32'h6);
    wr(usb_reset_pkg::addr_serial_ctrl, 32'h5a);
  endtask

  task automatic kept_common();
    rd_chk(usb_reset_pkg::addr_bulk_in_cs, 32'h0);
    rd_chk(usb_reset_pkg::addr_bulk_out_cs, 32'hff);
    rd_chk(usb_reset_pkg::addr_toggle, 32'h0);
    rd_chk(usb_reset_pkg::addr_function_addr, 32'h0);
    rd_chk(usb_reset_pkg::addr_config, 32'h0);
    rd_chk(usb_reset_pkg::addr_cpu_cs, 32'h2);
    rd_chk(usb_reset_pkg::addr_irq_enable, 32'hf);
    rd_chk(usb_reset_pkg::addr_usb_cs, 32'h6);
    rd_chk(usb_reset_pkg::addr_serial_ctrl, 32'h5a);
  endtask

  initial
  begin
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    check_table("power on");
    wr(usb_reset_pkg::addr_cpu_cs, 32'h2);
    rd_chk(usb_reset_pkg::addr_bulk_out_cs, 32'hff);
    wr(usb_reset_pkg::addr_in_bc_base + 8'h08, 32'h10);
    rd_chk(usb_reset_pkg::addr_bulk_in_cs, 32'h4);
    set_state();
    host_mode <= 2'd1;
    repeat (reset_len + 5) @(posedge clock);
    host_mode <= 2'd0;
    wait_irq(usb_reset_pkg::vector_reset);
    kept_common();
    rd_chk(usb_reset_pkg::addr_stall, 32'h00030005);
    wr(usb_reset_pkg::addr_status, 32'h1);
    @(posedge clock);
    `CHK(irq, 1'b0)
    $display("test bus reset done");
    wr(usb_reset_pkg::addr_in_bc_base + 8'h08, 32'h10);
    set_state();
    wr(usb_reset_pkg::addr_event, 32'h1);
    kept_common();
    rd_chk(usb_reset_pkg::addr_stall, 32'h0);
    $display("test disconnect done");
    set_state();
    wr(usb_reset_pkg::addr_cpu_cs, 32'h3);
    @(negedge clock);
    `CHK(cpu_reset, 1'b1)
    rd_chk(usb_reset_pkg::addr_bulk_out_cs, 32'h0);
    rd_chk(usb_reset_pkg::addr_irq_enable, 32'h0);
    rd_chk(usb_reset_pkg::addr_stall, 32'h00030005);
    rd_chk(usb_reset_pkg::addr_function_addr, 32'h5);
    rd_chk(usb_reset_pkg::addr_toggle, 32'h0000abcd);
    rd_chk(usb_reset_pkg::addr_usb_cs, 32'h6);
    wr(usb_reset_pkg::addr_cpu_cs, 32'h2);
    rd_chk(usb_reset_pkg::addr_bulk_out_cs, 32'hff);
    $display("test processor reset done");
    wake_n <= 1'b0;
    host_mode <= 2'd2;
    repeat (idle_len + 8) @(posedge clock);
    `CHK(irq, 1'b0)
    host_mode <= 2'd0;
    repeat (2) @(posedge clock);
    wake_n <= 1'b1;
    host_mode <= 2'd2;
    wait_irq(usb_reset_pkg::vector_suspend);
    `CHK(osc_en, 1'b1)
    wr(usb_reset_pkg::addr_status, 32'h1);
    cpu_idle <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK(osc_en, 1'b0)
    host_mode <= 2'd0;
    cpu_idle <= 1'b0;
    repeat (4) @(posedge clock);
    `CHK(osc_en, 1'b1)
    rd_chk(usb_reset_pkg::addr_usb_cs, 32'h6);
    host_mode <= 2'd2;
    wait_irq(usb_reset_pkg::vector_suspend);
    cpu_idle <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK(osc_en, 1'b0)
    wake_n <= 1'b0;
    cpu_idle <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK(osc_en, 1'b1)
    rd_chk(usb_reset_pkg::addr_usb_cs, 32'h86);
    $display("test suspend done");
    wake_n <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK(ser_rst, 1'b1)
    `CHK(clk_oe, 1'b1)
    rst_n <= 1'b1;
    check_table("reset pin");
    wrap_up();
  end
endmodule
